// ### sfwx_cfg.svh
// sfwx_cfg.svh: offsets, field positions, reset values and counts shared by
// both ends of the widened synchronous fifo.
// assumes: included by bare name from packages and modules.
`ifndef SFWX_CFG_SVH
`define SFWX_CFG_SVH

// one slice of the word and its storage
`define SFWX_SLICE_W         9
`define SFWX_DEPTH_DEFAULT   64
`define SFWX_SLICES_DEFAULT  2
`define SFWX_OFS_W           8
`define SFWX_OFS_DEFAULT     7

// flag levels seen right after reset
`define SFWX_EMPTY_N_RST     1'b0
`define SFWX_FULL_N_RST      1'b1
`define SFWX_AEMPTY_RST      1'b0
`define SFWX_AFULL_RST       1'b1

// controller register byte addresses
`define SFWX_ADDR_CTRL       8'h00
`define SFWX_ADDR_WDATA      8'h04
`define SFWX_ADDR_CMD        8'h08
`define SFWX_ADDR_OFFSET     8'h0c
`define SFWX_ADDR_STATUS     8'h10
`define SFWX_ADDR_IRQ_STAT   8'h14
`define SFWX_ADDR_IRQ_MASK   8'h18
`define SFWX_ADDR_RDATA      8'h1c

// ctrl fields
`define SFWX_CTRL_RST_BIT    0
`define SFWX_CTRL_DUAL_BIT   1
`define SFWX_CTRL_W          2
`define SFWX_CTRL_RST_VAL    2'h0

// cmd field
`define SFWX_CMD_POP_BIT     0

// status fields
`define SFWX_ST_EMPTY_BIT    0
`define SFWX_ST_FULL_BIT     1
`define SFWX_ST_AEMPTY_BIT   2
`define SFWX_ST_AFULL_BIT    3
`define SFWX_ST_PEND_BIT     4

// interrupt status / mask layout
`define SFWX_IRQ_W           5
`define SFWX_IRQ_WR_REFUSED  0
`define SFWX_IRQ_RD_REFUSED  1
`define SFWX_IRQ_FULL        2
`define SFWX_IRQ_EMPTY       3
`define SFWX_IRQ_RD_DONE     4
`define SFWX_IRQ_RST_VAL     5'h00

`endif

// ### sfwx_pkg.sv
// sfwx_pkg.sv: types shared by both ends of the widened fifo.
// assumes: sfwx_cfg.svh on the include path.
`include "sfwx_cfg.svh"

package sfwx_pkg;

    typedef logic [`SFWX_SLICE_W-1:0] sfwx_word_t;
    typedef logic [`SFWX_OFS_W-1:0]   sfwx_ofs_t;

    // one-cycle operation that the controller puts on the shared enables
    typedef enum logic [1:0] {
        SFWX_OP_IDLE  = 2'b00,
        SFWX_OP_WRITE = 2'b01,
        SFWX_OP_READ  = 2'b10,
        SFWX_OP_LOAD  = 2'b11
    } sfwx_op_e;

endpackage : sfwx_pkg

// ### sfwx_if.sv
// sfwx_if.sv: shared enables, sliced data and per-slice flags between the
// controller and the paralleled fifo slices.
// assumes: every slice and the controller run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sfwx_cfg.svh"

interface sfwx_if #(
    parameter int SLICES = `SFWX_SLICES_DEFAULT
);
    logic                             fifo_rst;
    logic                             write_enable_primary_n;
    logic                             write_enable_secondary_or_load;
    logic                             read_enable_primary_n;
    logic                             read_enable_secondary_n;
    logic [SLICES*`SFWX_SLICE_W-1:0]  wr_data;
    logic [SLICES*`SFWX_SLICE_W-1:0]  rd_data;
    logic [SLICES-1:0]                empty_flag_n;
    logic [SLICES-1:0]                full_flag_n;
    logic [SLICES-1:0]                almost_empty_flag;
    logic [SLICES-1:0]                almost_full_flag;

    modport dev (
        input  fifo_rst,
        input  write_enable_primary_n,
        input  write_enable_secondary_or_load,
        input  read_enable_primary_n,
        input  read_enable_secondary_n,
        input  wr_data,
        output rd_data,
        output empty_flag_n,
        output full_flag_n,
        output almost_empty_flag,
        output almost_full_flag
    );

    modport ctl (
        output fifo_rst,
        output write_enable_primary_n,
        output write_enable_secondary_or_load,
        output read_enable_primary_n,
        output read_enable_secondary_n,
        output wr_data,
        input  rd_data,
        input  empty_flag_n,
        input  full_flag_n,
        input  almost_empty_flag,
        input  almost_full_flag
    );
endinterface : sfwx_if

`default_nettype wire

// ### sfwx_slice.sv
// sfwx_slice.sv: one 9-bit fifo slice with empty, full and programmable
// almost flags, and the offset load sequence.
// assumes: enables come from logic on ref_clk_i (write and read clocks tied
// together); the slice drives only its own bits of the shared vectors.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sfwx_cfg.svh"

// What this block does
// - all slices share identical write/read controls
// - system combines empty and full across slices
// - almost flags taken from any one slice
// - each slice carries nine bits of word
// - second read enable may be grounded
// - load pin low at reset: load mode
// - four flags, all changing on clock edges
// - full flag low when storage full
// - writes ignored while full flag low
// - full flag updated on write clock only
// - empty flag low when nothing unread
// - reads ignored while empty flag low
// - empty flag updated on read clock only
// - almost-empty low while n or fewer words
// - almost-full high while free exceeds m
// - offsets n and m default to seven
// - load pin high at reset: second enable
module sfwx_slice
    import sfwx_pkg::*;
#(
    parameter int IDX    = 0,
    parameter int SLICES = `SFWX_SLICES_DEFAULT,
    parameter int DEPTH  = `SFWX_DEPTH_DEFAULT,
    parameter int AW     = $clog2(DEPTH)
) (
    sfwx_if.dev              link,
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    output logic [AW:0]      level_o,
    output logic             dual_enable_o
);

    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    if (DEPTH != (1 << AW) || DEPTH < 4 || DEPTH > 65536) begin : g_chk_depth
        $error("sfwx_slice: DEPTH must be a power of two from 4 to 65536");
    end
    if (IDX < 0 || IDX >= SLICES) begin : g_chk_idx
        $error("sfwx_slice: IDX outside the slice range");
    end

    sfwx_word_t            mem [DEPTH];
    sfwx_word_t            din;

    logic [AW-1:0]         wptr_q, wptr_d;
    logic [AW-1:0]         rptr_q, rptr_d;
    logic [AW:0]           count_q, count_d;
    logic                  empty_n_q, empty_n_d;
    logic                  full_n_q, full_n_d;
    logic                  aempty_q, aempty_d;
    logic                  afull_q, afull_d;
    sfwx_word_t            rd_q, rd_d;
    logic                  dual_q, dual_d;
    sfwx_ofs_t             ofs_q [4];
    sfwx_ofs_t             ofs_d [4];
    logic [1:0]            wsel_q, wsel_d;
    logic [1:0]            rsel_q, rsel_d;

    logic                  wr_req, rd_req, wr_ok, rd_ok;
    logic                  ld_wr, ld_rd;
    logic [15:0]           ofs_n, ofs_m;
    logic [AW:0]           free_d;

    assign din = link.wr_data[IDX*`SFWX_SLICE_W +: `SFWX_SLICE_W];

    // load pin acts as load only in the mode latched at reset
    assign ld_wr = !link.fifo_rst && !dual_q && !link.write_enable_primary_n
                   && !link.write_enable_secondary_or_load;
    assign ld_rd = !link.fifo_rst && !dual_q && !link.write_enable_secondary_or_load
                   && !link.read_enable_primary_n && !link.read_enable_secondary_n;

    // both modes write on primary low and secondary/load high
    assign wr_req = !link.fifo_rst && !link.write_enable_primary_n
                    && link.write_enable_secondary_or_load;
    assign rd_req = !link.fifo_rst && !link.read_enable_primary_n
                    && !link.read_enable_secondary_n && !ld_rd;
    assign wr_ok  = wr_req && full_n_q;
    assign rd_ok  = rd_req && empty_n_q;

    assign ofs_n = {ofs_q[1], ofs_q[0]};
    assign ofs_m = {ofs_q[3], ofs_q[2]};

    always_comb begin
        wptr_d  = wptr_q;
        rptr_d  = rptr_q;
        count_d = count_q;
        rd_d    = rd_q;
        dual_d  = dual_q;
        wsel_d  = wsel_q;
        rsel_d  = rsel_q;
        for (int i = 0; i < 4; i++) begin
            ofs_d[i] = ofs_q[i];
        end
        if (link.fifo_rst) begin
            // the pin level seen during reset picks the pin's role
            dual_d  = link.write_enable_secondary_or_load;
            wptr_d  = '0;
            rptr_d  = '0;
            count_d = '0;
            wsel_d  = 2'h0;
            rsel_d  = 2'h0;
            for (int i = 0; i < 4; i++) begin
                ofs_d[i] = (i % 2 == 0) ? sfwx_ofs_t'(`SFWX_OFS_DEFAULT) : '0;
            end
        end else begin
            if (wr_ok) begin
                wptr_d = wptr_q + 1'b1;
            end
            if (rd_ok) begin
                rptr_d = rptr_q + 1'b1;
                rd_d   = mem[rptr_q];
            end
            count_d = count_q + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
            // offsets load in order: empty lsb, empty msb, full lsb, full msb
            if (ld_wr) begin
                ofs_d[wsel_q] = din[`SFWX_OFS_W-1:0];
                wsel_d        = wsel_q + 1'b1;
            end
            if (ld_rd) begin
                rd_d   = sfwx_word_t'(ofs_q[rsel_q]);
                rsel_d = rsel_q + 1'b1;
            end
        end
    end

    // flags are registered from the next count, so each moves only on an edge
    always_comb begin
        free_d    = DEPTH_C - count_d;
        full_n_d  = (count_d != DEPTH_C);
        empty_n_d = (count_d != '0);
        aempty_d  = (17'(count_d) > {1'b0, ofs_n});
        afull_d   = (17'(free_d) > {1'b0, ofs_m});
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
            rd_q    <= '0;
            dual_q  <= 1'b0;
            wsel_q  <= 2'h0;
            rsel_q  <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                ofs_q[i] <= (i % 2 == 0) ? sfwx_ofs_t'(`SFWX_OFS_DEFAULT) : '0;
            end
        end else begin
            wptr_q  <= wptr_d;
            rptr_q  <= rptr_d;
            count_q <= count_d;
            rd_q    <= rd_d;
            dual_q  <= dual_d;
            wsel_q  <= wsel_d;
            rsel_q  <= rsel_d;
            for (int i = 0; i < 4; i++) begin
                ofs_q[i] <= ofs_d[i];
            end
        end
    end

    // write-clock flags: full and almost full
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            full_n_q <= `SFWX_FULL_N_RST;
            afull_q  <= `SFWX_AFULL_RST;
        end else begin
            full_n_q <= full_n_d;
            afull_q  <= afull_d;
        end
    end

    // read-clock flags: empty and almost empty
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            empty_n_q <= `SFWX_EMPTY_N_RST;
            aempty_q  <= `SFWX_AEMPTY_RST;
        end else begin
            empty_n_q <= empty_n_d;
            aempty_q  <= aempty_d;
        end
    end

    // storage has no reset: contents are meaningless until written
    always_ff @(posedge ref_clk_i) begin
        if (wr_ok) begin
            mem[wptr_q] <= din;
        end
    end

    // each slice owns only its own bits of the shared vectors
    assign link.rd_data[IDX*`SFWX_SLICE_W +: `SFWX_SLICE_W] = rd_q;
    assign link.empty_flag_n[IDX]      = empty_n_q;
    assign link.full_flag_n[IDX]       = full_n_q;
    assign link.almost_empty_flag[IDX] = aempty_q;
    assign link.almost_full_flag[IDX]  = afull_q;

    assign level_o       = count_q;
    assign dual_enable_o = dual_q;

endmodule : sfwx_slice

`default_nettype wire

// ### sfwx_ctrl.sv
// sfwx_ctrl.sv: apb-controlled writer/reader driving paralleled fifo slices
// from common enables, with combined flags and an interrupt.
// assumes: apb master on ref_clk_i; slices on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sfwx_cfg.svh"

module sfwx_ctrl
    import sfwx_pkg::*;
#(
    parameter int SLICES = `SFWX_SLICES_DEFAULT
) (
    sfwx_if.ctl                 link,
    input  wire logic           ref_clk_i,
    input  wire logic           rst_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [7:0]     paddr_i,
    input  wire logic [31:0]    pwdata_i,
    output logic [31:0]         prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    output logic                irq_o
);

    localparam int DW = SLICES * `SFWX_SLICE_W;

    if (SLICES < 1 || DW > 32) begin : g_chk_slices
        $error("sfwx_ctrl: word must fit one 32-bit register");
    end

    sfwx_op_e                  op_q, op_d;
    logic [DW-1:0]             wdat_q, wdat_d;
    logic [DW-1:0]             rdat_q, rdat_d;
    logic                      pend_q, pend_d;
    logic [`SFWX_CTRL_W-1:0]   ctrl_q, ctrl_d;
    logic [`SFWX_IRQ_W-1:0]    stat_q, stat_d;
    logic [`SFWX_IRQ_W-1:0]    mask_q, mask_d;
    logic [31:0]               prdata_q, prdata_d;
    logic                      full_prev_q, full_prev_d;
    logic                      empty_prev_q, empty_prev_d;

    logic                      comb_empty, comb_full, mapped, acc_wr;
    logic [`SFWX_IRQ_W-1:0]    ev;
    logic [31:0]               status_w;

    function automatic logic addr_known(input logic [7:0] a);
        unique case (a)
            `SFWX_ADDR_CTRL, `SFWX_ADDR_WDATA, `SFWX_ADDR_CMD, `SFWX_ADDR_OFFSET,
            `SFWX_ADDR_STATUS, `SFWX_ADDR_IRQ_STAT, `SFWX_ADDR_IRQ_MASK,
            `SFWX_ADDR_RDATA: addr_known = 1'b1;
            default:          addr_known = 1'b0;
        endcase
    endfunction : addr_known

    assign comb_empty = |(~link.empty_flag_n);
    assign comb_full  = |(~link.full_flag_n);
    assign mapped     = addr_known(paddr_i);
    assign acc_wr     = psel_i && penable_i && pwrite_i && mapped;

    assign status_w = 32'({pend_q, link.almost_full_flag[0],
                           link.almost_empty_flag[0], comb_full, comb_empty});

    always_comb begin
        op_d         = SFWX_OP_IDLE;
        wdat_d       = wdat_q;
        rdat_d       = rdat_q;
        // word lands in the slices one edge after the read pulse
        pend_d       = (op_q == SFWX_OP_READ);
        ctrl_d       = ctrl_q;
        mask_d       = mask_q;
        prdata_d     = prdata_q;
        full_prev_d  = comb_full;
        empty_prev_d = comb_empty;
        ev           = '0;
        // capture the word one cycle after the slices took the read
        if (pend_q) begin
            rdat_d = link.rd_data;
            ev[`SFWX_IRQ_RD_DONE] = 1'b1;
        end
        ev[`SFWX_IRQ_FULL]  = comb_full && !full_prev_q;
        ev[`SFWX_IRQ_EMPTY] = comb_empty && !empty_prev_q;
        if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                `SFWX_ADDR_CTRL:     prdata_d = 32'(ctrl_q);
                `SFWX_ADDR_WDATA:    prdata_d = 32'(wdat_q);
                `SFWX_ADDR_STATUS:   prdata_d = status_w;
                `SFWX_ADDR_IRQ_STAT: prdata_d = 32'(stat_q);
                `SFWX_ADDR_IRQ_MASK: prdata_d = 32'(mask_q);
                `SFWX_ADDR_RDATA:    prdata_d = 32'(rdat_q);
                default:             prdata_d = '0;
            endcase
        end
        if (acc_wr) begin
            unique case (paddr_i)
                `SFWX_ADDR_CTRL:     ctrl_d = pwdata_i[`SFWX_CTRL_W-1:0];
                `SFWX_ADDR_IRQ_MASK: mask_d = pwdata_i[`SFWX_IRQ_W-1:0];
                `SFWX_ADDR_WDATA: begin
                    // a refused write never reaches any slice
                    if (comb_full || ctrl_q[`SFWX_CTRL_RST_BIT]) begin
                        ev[`SFWX_IRQ_WR_REFUSED] = 1'b1;
                    end else begin
                        op_d   = SFWX_OP_WRITE;
                        wdat_d = pwdata_i[DW-1:0];
                    end
                end
                `SFWX_ADDR_CMD: begin
                    if (pwdata_i[`SFWX_CMD_POP_BIT]) begin
                        if (comb_empty || ctrl_q[`SFWX_CTRL_RST_BIT]) begin
                            ev[`SFWX_IRQ_RD_REFUSED] = 1'b1;
                        end else begin
                            op_d   = SFWX_OP_READ;
                        end
                    end
                end
                `SFWX_ADDR_OFFSET: begin
                    if (!ctrl_q[`SFWX_CTRL_RST_BIT] && !ctrl_q[`SFWX_CTRL_DUAL_BIT]) begin
                        op_d   = SFWX_OP_LOAD;
                        wdat_d = DW'(pwdata_i[`SFWX_OFS_W-1:0]) << 0;
                        for (int s = 0; s < SLICES; s++) begin
                            wdat_d[s*`SFWX_SLICE_W +: `SFWX_OFS_W] = pwdata_i[`SFWX_OFS_W-1:0];
                        end
                    end
                end
                default: ;
            endcase
        end
        // set wins over a same-cycle write-one-to-clear
        stat_d = stat_q;
        if (acc_wr && paddr_i == `SFWX_ADDR_IRQ_STAT) begin
            stat_d = stat_q & ~pwdata_i[`SFWX_IRQ_W-1:0];
        end
        stat_d = stat_d | ev;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_q         <= SFWX_OP_IDLE;
            wdat_q       <= '0;
            rdat_q       <= '0;
            pend_q       <= 1'b0;
            ctrl_q       <= `SFWX_CTRL_RST_VAL;
            stat_q       <= `SFWX_IRQ_RST_VAL;
            mask_q       <= `SFWX_IRQ_RST_VAL;
            prdata_q     <= '0;
            full_prev_q  <= 1'b0;
            empty_prev_q <= 1'b1;
        end else begin
            op_q         <= op_d;
            wdat_q       <= wdat_d;
            rdat_q       <= rdat_d;
            pend_q       <= pend_d;
            ctrl_q       <= ctrl_d;
            stat_q       <= stat_d;
            mask_q       <= mask_d;
            prdata_q     <= prdata_d;
            full_prev_q  <= full_prev_d;
            empty_prev_q <= empty_prev_d;
        end
    end

    // one driver per control, fanned out to every slice
    assign link.fifo_rst                       = ctrl_q[`SFWX_CTRL_RST_BIT];
    assign link.write_enable_primary_n         = !(op_q == SFWX_OP_WRITE || op_q == SFWX_OP_LOAD);
    // during reset the strap level, default low, picks load mode
    assign link.write_enable_secondary_or_load = ctrl_q[`SFWX_CTRL_RST_BIT] ?
                                                 ctrl_q[`SFWX_CTRL_DUAL_BIT] : (op_q != SFWX_OP_LOAD);
    assign link.read_enable_primary_n          = (op_q != SFWX_OP_READ);
    assign link.read_enable_secondary_n        = 1'b0;
    assign link.wr_data                        = wdat_q;

    assign prdata_o  = prdata_q;
    assign pready_o  = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign irq_o     = |(stat_q & mask_q);

endmodule : sfwx_ctrl

`default_nettype wire

// ### sfwx_assertions.sv
// sfwx_assertions.sv: flag and enable checks on the link between the slices and the controller.
// assumes: instantiated beside sfwx_if, one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
`include "sfwx_cfg.svh"
module sfwx_assertions #(
    parameter int SLICES = `SFWX_SLICES_DEFAULT
) (
    input wire logic              ref_clk_i,
    input wire logic              rst_i,
    input wire logic              fifo_rst,
    input wire logic              write_enable_primary_n,
    input wire logic              read_enable_primary_n,
    input wire logic              read_enable_secondary_n,
    input wire logic [SLICES-1:0] empty_flag_n,
    input wire logic [SLICES-1:0] full_flag_n,
    input wire logic [SLICES-1:0] almost_empty_flag,
    input wire logic [SLICES-1:0] almost_full_flag
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_full_blocks_wr: assert property (!full_flag_n[0] && read_enable_primary_n
        && !fifo_rst |=> !full_flag_n[0]) else $error("write stored while full");
    a_empty_blocks_rd: assert property (!empty_flag_n[0] && write_enable_primary_n
        && !fifo_rst |=> !empty_flag_n[0]) else $error("read taken while empty");
    a_full_after_wr: assert property ($fell(full_flag_n[0]) |-> !$past(write_enable_primary_n))
        else $error("full flag fell without a write");
    a_empty_after_rd: assert property ($fell(empty_flag_n[0]) |->
        !$past(read_enable_primary_n) || $past(fifo_rst)) else $error("empty flag fell without a read");
    a_aempty_needs_wr: assert property ($rose(almost_empty_flag[0]) |-> !$past(write_enable_primary_n))
        else $error("almost empty rose without a write");
    a_afull_needs_wr: assert property ($fell(almost_full_flag[0]) |-> !$past(write_enable_primary_n))
        else $error("almost full fell without a write");
    a_slices_agree: assert property ((&empty_flag_n || ~|empty_flag_n) && (&full_flag_n || ~|full_flag_n))
        else $error("slices disagree on empty or full");
    a_fifo_rst_flags: assert property (fifo_rst |=> ~|empty_flag_n && &full_flag_n
        && ~|almost_empty_flag && &almost_full_flag) else $error("flags not at reset levels");
    a_read_enable_secondary_n_grounded: assert property (!read_enable_secondary_n) else $error("second read enable not low");
endmodule : sfwx_assertions
`default_nettype wire

// ### sfwx_tb.sv
// sfwx_tb.sv: controller and two slices joined by sfwx_if, driven over apb.
// assumes: default offsets, then offsets 2 and 5 loaded; depth 64, irq status sticky regardless of mask.
`timescale 1ns/1ps
`default_nettype none
`include "sfwx_cfg.svh"
module sfwx_tb;
    localparam int DEPTH = 64;
    logic        ref_clk_i = 1'b0;
    logic        rst_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rdat;
    logic        serr;
    logic [6:0]  lvl [2];
    logic        dual [2];
    int          seed = 32'hf500;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    sfwx_if #(.SLICES(2)) link ();
    sfwx_ctrl #(.SLICES(2)) u_sfwx_ctrl (.link(link), .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
    for (genvar g = 0; g < 2; g++) begin : g_sl
        sfwx_slice #(.IDX(g), .SLICES(2)) u_sfwx_slice (.link(link), .ref_clk_i(ref_clk_i), .rst_i(rst_i),
            .level_o(lvl[g]), .dual_enable_o(dual[g]));
    end
    sfwx_assertions #(.SLICES(2)) u_sfwx_assertions (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .fifo_rst(link.fifo_rst), .write_enable_primary_n(link.write_enable_primary_n),
        .read_enable_primary_n(link.read_enable_primary_n), .read_enable_secondary_n(link.read_enable_secondary_n),
        .empty_flag_n(link.empty_flag_n), .full_flag_n(link.full_flag_n),
        .almost_empty_flag(link.almost_empty_flag), .almost_full_flag(link.almost_full_flag));
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: exp %h got %h", $time, e, g);
        end
    endtask : cmp
    // slack after each transfer lets enables, flags and read data land
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask : apb
    function automatic logic [31:0] st(input int c, input int n, input int m);
        return {28'h0, DEPTH - c > m, c > n, c == DEPTH, c == 0};
    endfunction : st
    // fill one past full, then drain one past empty
    task automatic run(input int n, input int m);
        logic [17:0] q[$];
        logic [17:0] w;
        apb(1'b1, `SFWX_ADDR_IRQ_STAT, 32'h1f);
        for (int i = 0; i <= DEPTH; i++) begin
            w = 18'($random(seed));
            apb(1'b1, `SFWX_ADDR_WDATA, {14'h0, w});
            if (i < DEPTH) q.push_back(w);
            apb(1'b0, `SFWX_ADDR_STATUS, 32'h0);
            cmp(st(q.size(), n, m), rdat & 32'hf);
        end
        apb(1'b0, `SFWX_ADDR_IRQ_STAT, 32'h0);
        cmp(32'h05, rdat);
        cmp(DEPTH, lvl[1]);
        cmp(32'h1, irq);
        apb(1'b1, `SFWX_ADDR_IRQ_STAT, 32'h1f);
        for (int i = 0; i <= DEPTH; i++) begin
            apb(1'b1, `SFWX_ADDR_CMD, 32'h1);
            if (i < DEPTH) begin
                apb(1'b0, `SFWX_ADDR_RDATA, 32'h0);
                cmp({14'h0, q.pop_front()}, rdat);
            end
            apb(1'b0, `SFWX_ADDR_STATUS, 32'h0);
            cmp(st(q.size(), n, m), rdat & 32'hf);
        end
        apb(1'b0, `SFWX_ADDR_IRQ_STAT, 32'h0);
        cmp(32'h1a, rdat);
        cmp(32'h0, lvl[0]);
    endtask : run
    initial begin
        rst_i   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        apb(1'b0, 8'h20, 32'h0);
        cmp(32'h0, rdat);
        cmp(32'h1, serr);
        apb(1'b0, `SFWX_ADDR_STATUS, 32'h0);
        cmp(32'h09, rdat & 32'hf);
        apb(1'b1, `SFWX_ADDR_CMD, 32'h1);
        apb(1'b0, `SFWX_ADDR_IRQ_STAT, 32'h0);
        cmp(32'h02, rdat);
        cmp(32'h0, irq);
        apb(1'b1, `SFWX_ADDR_IRQ_MASK, 32'h1f);
        cmp(32'h1, irq);
        apb(1'b1, `SFWX_ADDR_IRQ_STAT, 32'h1f);
        cmp(32'h0, irq);
        run(7, 7);
        apb(1'b1, `SFWX_ADDR_CTRL, 32'h3);
        apb(1'b1, `SFWX_ADDR_CTRL, 32'h2);
        cmp(32'h1, dual[0]);
        apb(1'b1, `SFWX_ADDR_WDATA, 32'h155);
        apb(1'b0, `SFWX_ADDR_STATUS, 32'h0);
        cmp(32'h08, rdat & 32'hf);
        apb(1'b1, `SFWX_ADDR_CTRL, 32'h1);
        apb(1'b1, `SFWX_ADDR_CTRL, 32'h0);
        cmp(32'h0, dual[0]);
        apb(1'b0, `SFWX_ADDR_STATUS, 32'h0);
        cmp(32'h09, rdat & 32'hf);
        apb(1'b1, `SFWX_ADDR_OFFSET, 32'h2);
        apb(1'b1, `SFWX_ADDR_OFFSET, 32'h0);
        apb(1'b1, `SFWX_ADDR_OFFSET, 32'h5);
        apb(1'b1, `SFWX_ADDR_OFFSET, 32'h0);
        run(2, 5);
        give_verdict();
    end
endmodule : sfwx_tb
`default_nettype wire
